/* rtl/sdrep_pkg.sv */
// Package with register indices, field positions, reset values and drop reason codes.
`default_nettype none
package sdrep_pkg;
  localparam int SDREP_ADDR_W = 16;
  localparam int SDREP_DATA_W = 32;
  localparam logic [15:0] SDREP_IDX_P2_DROP_CNT = 16'h1c18;
  localparam logic [15:0] SDREP_IDX_INT_MASK = 16'h1c20;
  localparam logic [15:0] SDREP_IDX_INT_PEND = 16'h1c21;
  localparam logic [31:0] SDREP_CNT_RESET = 32'h00000000;
  localparam logic [31:0] SDREP_CNT_MAX = 32'hffffffff;
  localparam logic SDREP_MASK_RESET = 1'h1;
  localparam int SDREP_MASK_BIT = 0;
  localparam int SDREP_A_VALID_BIT = 0;
  localparam int SDREP_A_PORT_LSB = 1;
  localparam int SDREP_A_REASON_LSB = 3;
  localparam int SDREP_B_PEND_BIT = 7;
  localparam int SDREP_B_PORT_LSB = 8;
  localparam int SDREP_B_REASON_LSB = 10;
  localparam logic [1:0] SDREP_PORT_0 = 2'h0;
  localparam logic [1:0] SDREP_PORT_1 = 2'h1;
  localparam logic [1:0] SDREP_PORT_2 = 2'h2;
  localparam logic [1:0] SDREP_PORT_RSVD = 2'h3;
  localparam logic [3:0] SDREP_RSN_BCAST_LEVEL = 4'h0;
  localparam logic [3:0] SDREP_RSN_RED = 4'h1;
  localparam logic [3:0] SDREP_RSN_NO_BUF = 4'h2;
  localparam logic [3:0] SDREP_RSN_NO_DESC = 4'h3;
  localparam logic [3:0] SDREP_RSN_NO_DEST = 4'h4;
  localparam logic [3:0] SDREP_RSN_RX_ERR = 4'h5;
  localparam logic [3:0] SDREP_RSN_DROP_LEVEL = 4'h6;
  localparam logic [3:0] SDREP_RSN_YELLOW = 4'h9;
endpackage
`default_nettype wire

/* rtl/sdrep_drop_report.sv */
// Drop event reporting: port 2 ingress drop counter, interrupt mask and double-buffered pending record.
//
// Function
// RQ1: The counter advances once per port 2 packet dropped by ingress rate limiting, red or random yellow.
// RQ2: The counter stops at all ones instead of wrapping.
// RQ3: Reading the counter returns its value and clears it, and it reads zero after reset.
// RQ4: Mask bit 0 blocks all drop interrupts when one, passes them when zero, and resets to one.
// RQ5: The mask affects only the interrupt output, never capture of the pending fields.
// RQ6: The pending register holds two independent drop records, set A and set B; here set B fills only while set A is held, and one read clears both.
// RQ7: Bit 0 flags set A valid, meaning bits 6 to 1 hold a captured drop.
// RQ8: Bits 6 to 3 hold the set A reason with the same encoding as set B.
// RQ9: Bits 2 to 1 hold the set A source port, 00 port 0, 01 port 1, 10 port 2, 11 reserved.
// RQ10: Bit 7 flags set B pending, meaning bits 13 to 8 hold a captured drop.
// RQ11: Bits 9 to 8 hold the set B source port with the set A port encoding.
// RQ12: Reason 0000 is broadcast level exceeded and 0100 is no valid destination port.
// RQ13: Reason 0001 is a red drop and 1001 is a random yellow drop.
// RQ14: Reason 0010 is no free buffer, 0011 no free descriptor, 0110 buffer drop level exceeded.
// RQ15: Reason 0101 is a receive error on a packet over 64 bytes, and reserved codes are never reported.
// RQ16: A drop fills set A if free, else set B if free, else is lost, and a pending read clears all fields.
// RQ17: The interrupt is high while either record is held and the mask bit is zero.
`default_nettype none
module sdrep_drop_report
  import sdrep_pkg::*;
#(
  parameter int CNT_W = SDREP_DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic p2_rate_drop_i,
  input wire logic drop_event_i,
  input wire logic [3:0] drop_reason_i,
  input wire logic [1:0] drop_port_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [sdrep_pkg::SDREP_ADDR_W-1:0] reg_addr_i,
  input wire logic [sdrep_pkg::SDREP_DATA_W-1:0] reg_wdata_i,
  output logic [sdrep_pkg::SDREP_DATA_W-1:0] reg_rdata_o,
  output logic drop_irq_o
);
  import sdrep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  logic sel_cnt;
  logic sel_mask;
  logic sel_pend;
  logic rd_cnt;
  logic rd_pend;
  assign sel_cnt = (reg_addr_i == SDREP_IDX_P2_DROP_CNT);
  assign sel_mask = (reg_addr_i == SDREP_IDX_INT_MASK);
  assign sel_pend = (reg_addr_i == SDREP_IDX_INT_PEND);
  assign rd_cnt = reg_rd_i && sel_cnt;
  assign rd_pend = reg_rd_i && sel_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Port 2 ingress drop counter.
  logic [CNT_W-1:0] drop_cnt;
  logic cnt_full;
  assign cnt_full = (drop_cnt == SDREP_CNT_MAX[CNT_W-1:0]);

  // A drop in the same cycle as the clearing read restarts the count at one, so the event is not lost.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drop_cnt <= SDREP_CNT_RESET[CNT_W-1:0]; // RQ3
    end else if (rd_cnt) begin
      drop_cnt <= p2_rate_drop_i ? CNT_W'(1) : SDREP_CNT_RESET[CNT_W-1:0]; // RQ3
    end else if (p2_rate_drop_i && !cnt_full) begin
      drop_cnt <= drop_cnt + CNT_W'(1); // RQ1 RQ2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask.
  logic int_mask;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_mask <= SDREP_MASK_RESET; // RQ4
    end else if (reg_wr_i && sel_mask) begin
      int_mask <= reg_wdata_i[SDREP_MASK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending records. Capture ignores the mask entirely.
  logic a_valid;
  logic [3:0] a_reason;
  logic [1:0] a_port;
  logic b_pend;
  logic [3:0] b_reason;
  logic [1:0] b_port;
  logic reason_ok;
  logic take_a;
  logic take_b;

  // Reserved reason codes and port 11 are refused so they can never be reported.
  always_comb begin
    case (drop_reason_i)
      SDREP_RSN_BCAST_LEVEL, SDREP_RSN_NO_DEST: reason_ok = 1'b1; // RQ12
      SDREP_RSN_RED, SDREP_RSN_YELLOW: reason_ok = 1'b1; // RQ13
      SDREP_RSN_NO_BUF, SDREP_RSN_NO_DESC, SDREP_RSN_DROP_LEVEL: reason_ok = 1'b1; // RQ14
      SDREP_RSN_RX_ERR: reason_ok = 1'b1; // RQ15
      default: reason_ok = 1'b0; // RQ15
    endcase
  end

  // The read clears first, so a drop in that cycle lands in set A and is not lost.
  assign take_a = drop_event_i && reason_ok && (drop_port_i != SDREP_PORT_RSVD)
                  && (!a_valid || rd_pend); // RQ16 RQ9
  assign take_b = drop_event_i && reason_ok && (drop_port_i != SDREP_PORT_RSVD)
                  && a_valid && !b_pend && !rd_pend; // RQ16

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_valid <= 1'b0;
      a_reason <= 4'h0;
      a_port <= 2'h0;
    end else if (take_a) begin
      a_valid <= 1'b1; // RQ7
      a_reason <= drop_reason_i; // RQ8
      a_port <= drop_port_i; // RQ9
    end else if (rd_pend) begin
      a_valid <= 1'b0; // RQ16
      a_reason <= 4'h0;
      a_port <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      b_pend <= 1'b0;
      b_reason <= 4'h0;
      b_port <= 2'h0;
    end else if (rd_pend) begin
      b_pend <= 1'b0; // RQ16
      b_reason <= 4'h0;
      b_port <= 2'h0;
    end else if (take_b) begin
      b_pend <= 1'b1; // RQ10 RQ6
      b_reason <= drop_reason_i; // RQ12
      b_port <= drop_port_i; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt.
  logic [SDREP_DATA_W-1:0] pend_word;
  always_comb begin
    pend_word = '0;
    pend_word[SDREP_A_VALID_BIT] = a_valid; // RQ7
    pend_word[SDREP_A_PORT_LSB +: 2] = a_port; // RQ9
    pend_word[SDREP_A_REASON_LSB +: 4] = a_reason; // RQ8
    pend_word[SDREP_B_PEND_BIT] = b_pend; // RQ10
    pend_word[SDREP_B_PORT_LSB +: 2] = b_port; // RQ11
    pend_word[SDREP_B_REASON_LSB +: 4] = b_reason;
  end

  // Read data is registered: it appears the cycle after the read strobe and holds until the next read.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      if (sel_cnt) begin
        reg_rdata_o <= SDREP_DATA_W'(drop_cnt); // RQ3
      end else if (sel_mask) begin
        reg_rdata_o <= SDREP_DATA_W'(int_mask);
      end else if (sel_pend) begin
        reg_rdata_o <= pend_word;
      end else begin
        reg_rdata_o <= '0;
      end
    end
  end

  logic next_a_valid;
  logic next_b_pend;
  logic next_mask;
  assign next_a_valid = take_a || (a_valid && !rd_pend);
  assign next_b_pend = take_b || (b_pend && !rd_pend);
  assign next_mask = (reg_wr_i && sel_mask) ? reg_wdata_i[SDREP_MASK_BIT] : int_mask;

  // Built from next-state terms so the registered interrupt tracks the flags without an extra cycle of lag.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drop_irq_o <= 1'b0;
    end else begin
      drop_irq_o <= (next_a_valid || next_b_pend) && !next_mask; // RQ17 RQ5 RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_cnt_inc; // RQ1
    @(posedge clk_sys_i) disable iff (!resetn_i)
      p2_rate_drop_i && !rd_cnt && !cnt_full |=> drop_cnt == $past(drop_cnt) + CNT_W'(1);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("drop counter did not advance"); // RQ1

  property p_cnt_sat; // RQ2
    @(posedge clk_sys_i) disable iff (!resetn_i)
      cnt_full && !rd_cnt |=> cnt_full;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("drop counter wrapped"); // RQ2

  property p_cnt_clr; // RQ3
    @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_cnt && !p2_rate_drop_i |=> drop_cnt == '0 && reg_rdata_o == SDREP_DATA_W'($past(drop_cnt));
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter read did not return and clear"); // RQ3

  property p_irq_masked; // RQ4
    @(posedge clk_sys_i) disable iff (!resetn_i)
      int_mask |-> !drop_irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt passed while masked"); // RQ4

  sequence s_drop_a;
    take_a ##1 a_valid;
  endsequence
  property p_capture_a; // RQ5
    @(posedge clk_sys_i) disable iff (!resetn_i)
      take_a |-> s_drop_a ##0 (a_reason == $past(drop_reason_i) && a_port == $past(drop_port_i));
  endproperty
  a_capture_a: assert property (p_capture_a) else $error("set A capture wrong"); // RQ5

  property p_capture_b; // RQ6
    @(posedge clk_sys_i) disable iff (!resetn_i)
      take_b |=> b_pend && a_valid && b_reason == $past(drop_reason_i) && b_port == $past(drop_port_i);
  endproperty
  a_capture_b: assert property (p_capture_b) else $error("set B capture wrong"); // RQ6

  property p_full_drop; // RQ16
    @(posedge clk_sys_i) disable iff (!resetn_i)
      a_valid && b_pend && !rd_pend |=> $stable(a_reason) && $stable(b_reason) && $stable(b_port);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("record overwritten while full"); // RQ16

  property p_no_rsvd; // RQ15
    @(posedge clk_sys_i) disable iff (!resetn_i)
      a_valid |-> a_port != SDREP_PORT_RSVD && a_reason != 4'h7 && a_reason != 4'h8;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code reported"); // RQ15

  property p_irq_on; // RQ17
    @(posedge clk_sys_i) disable iff (!resetn_i)
      (a_valid || b_pend) && !int_mask && !rd_pend && !(reg_wr_i && sel_mask) |=> drop_irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing"); // RQ17

  // Reference decode of the drops that the reason and port tables allow, kept apart from the design's own.
  logic chk_listed;
  assign chk_listed = (drop_port_i != SDREP_PORT_RSVD)
                      && (drop_reason_i inside {SDREP_RSN_BCAST_LEVEL, SDREP_RSN_RED, SDREP_RSN_NO_BUF,
                                                SDREP_RSN_NO_DESC, SDREP_RSN_NO_DEST, SDREP_RSN_RX_ERR,
                                                SDREP_RSN_DROP_LEVEL, SDREP_RSN_YELLOW});

  sequence s_listed_drop;
    drop_event_i && chk_listed;
  endsequence

  sequence s_slot_b;
    s_listed_drop ##0 (a_valid && !b_pend && !rd_pend);
  endsequence

  property p_fill_a; // RQ7
    @(posedge clk_sys_i) disable iff (!resetn_i)
      s_listed_drop ##0 !a_valid |=> a_valid && a_reason == $past(drop_reason_i) && a_port == $past(drop_port_i);
  endproperty
  a_fill_a: assert property (p_fill_a) else $error("set A not filled from a free slot"); // RQ7

  property p_fill_b; // RQ10
    @(posedge clk_sys_i) disable iff (!resetn_i)
      s_slot_b |=> b_pend && b_reason == $past(drop_reason_i) && b_port == $past(drop_port_i) && $stable(a_reason);
  endproperty
  a_fill_b: assert property (p_fill_b) else $error("set B not filled behind set A"); // RQ10

  property p_read_take; // RQ16
    @(posedge clk_sys_i) disable iff (!resetn_i)
      s_listed_drop ##0 rd_pend |=> a_valid && !b_pend && a_reason == $past(drop_reason_i);
  endproperty
  a_read_take: assert property (p_read_take) else $error("drop lost during pending read"); // RQ16

  property p_refused; // RQ15
    @(posedge clk_sys_i) disable iff (!resetn_i)
      drop_event_i && !chk_listed && !rd_pend |=> $stable(a_valid) && $stable(b_pend) && $stable(a_reason);
  endproperty
  a_refused: assert property (p_refused) else $error("refused drop was recorded"); // RQ15

  property p_pend_read; // RQ16
    @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_pend |=> reg_rdata_o == $past(pend_word);
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending read returned wrong word"); // RQ16

  property p_pend_clear; // RQ16
    @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_pend && !drop_event_i |=> pend_word == '0;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending read did not clear"); // RQ16

  property p_b_needs_a; // RQ6
    @(posedge clk_sys_i) disable iff (!resetn_i)
      b_pend |-> a_valid;
  endproperty
  a_b_needs_a: assert property (p_b_needs_a) else $error("set B held without set A"); // RQ6

  property p_no_rsvd_b; // RQ11
    @(posedge clk_sys_i) disable iff (!resetn_i)
      b_pend |-> b_port != SDREP_PORT_RSVD;
  endproperty
  a_no_rsvd_b: assert property (p_no_rsvd_b) else $error("reserved port in set B"); // RQ11

  property p_mask_write; // RQ4
    @(posedge clk_sys_i) disable iff (!resetn_i)
      reg_wr_i && sel_mask |=> int_mask == $past(reg_wdata_i[SDREP_MASK_BIT]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not taken"); // RQ4

  property p_mask_hold; // RQ4
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !(reg_wr_i && sel_mask) |=> $stable(int_mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without a write"); // RQ4

  property p_mask_read; // RQ4
    @(posedge clk_sys_i) disable iff (!resetn_i)
      reg_rd_i && sel_mask |=> reg_rdata_o == SDREP_DATA_W'($past(int_mask));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // RQ4

  property p_cnt_race; // RQ3
    @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_cnt && p2_rate_drop_i |=> drop_cnt == CNT_W'(1) && reg_rdata_o == SDREP_DATA_W'($past(drop_cnt));
  endproperty
  a_cnt_race: assert property (p_cnt_race) else $error("drop lost during counter read"); // RQ3

  property p_cnt_idle; // RQ1
    @(posedge clk_sys_i) disable iff (!resetn_i)
      !p2_rate_drop_i && !rd_cnt |=> $stable(drop_cnt);
  endproperty
  a_cnt_idle: assert property (p_cnt_idle) else $error("counter moved without a drop"); // RQ1

  property p_irq_level; // RQ17
    @(posedge clk_sys_i) disable iff (!resetn_i)
      drop_irq_o == ((a_valid || b_pend) && !int_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with flags"); // RQ17

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!resetn_i)
      reg_rd_i && !sel_cnt && !sel_mask && !sel_pend |=> reg_rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule // sdrep_drop_report
`default_nettype wire

/* tb/sdrep_tb.sv */
// Self-checking testbench for the drop event reporting block.
`default_nettype none
module testbench
  import sdrep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic p2_rate_drop_i = 1'b0;
  logic drop_event_i = 1'b0;
  logic [3:0] drop_reason_i = 4'h0;
  logic [1:0] drop_port_i = 2'h0;
  logic reg_rd_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic [31:0] reg_rdata_o;
  logic drop_irq_o;
  logic [31:0] rv;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  // A narrow counter lets saturation be reached in a few cycles.
  sdrep_drop_report #(.CNT_W(4)) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .p2_rate_drop_i(p2_rate_drop_i),
    .drop_event_i(drop_event_i), .drop_reason_i(drop_reason_i), .drop_port_i(drop_port_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .drop_irq_o(drop_irq_o)
  );
  always #50 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the whole run needs well under a thousand cycles.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      errors++;
    end
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
    tick();
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask
  task automatic drop(input logic [3:0] r, input logic [1:0] p);
    drop_reason_i = r;
    drop_port_i = p;
    drop_event_i = 1'b1;
    tick();
    drop_event_i = 1'b0;
    tick();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    chk(drop_irq_o, 1'b0);
    rd(16'h1c18, rv); chk(rv, 32'h00000000);
    rd(16'h1c20, rv); chk(rv, 32'h00000001);
    rd(16'h1c21, rv); chk(rv, 32'h00000000);
    rd(16'h1c1f, rv); chk(rv, 32'h00000000);
  endtask
  task automatic test_counter();
    wr(16'h1c18, 32'h00000005);
    rd(16'h1c18, rv); chk(rv, 32'h00000000);
    repeat (3) begin
      p2_rate_drop_i = 1'b1;
      tick();
      p2_rate_drop_i = 1'b0;
      tick();
    end
    rd(16'h1c18, rv); chk(rv, 32'h00000003);
    rd(16'h1c18, rv); chk(rv, 32'h00000000);
    p2_rate_drop_i = 1'b1;
    repeat (20) tick();
    p2_rate_drop_i = 1'b0;
    rd(16'h1c18, rv); chk(rv, 32'h0000000f);
    rd(16'h1c18, rv); chk(rv, 32'h00000000);
  endtask
  task automatic test_mask_reg();
    wr(16'h1c20, 32'hffffffff);
    rd(16'h1c20, rv); chk(rv, 32'h00000001);
    wr(16'h1c20, 32'h00000000);
    rd(16'h1c20, rv); chk(rv, 32'h00000000);
  endtask
  // Set A then set B fill, a third record is lost, and one read clears both.
  task automatic test_pending_codes();
    logic [3:0] rb;
    for (int i = 0; i < 8; i++) begin
      rb = codes[7 - i];
      drop(codes[i], 2'(i % 3));
      chk(drop_irq_o, 1'b1);
      drop(rb, 2'((i + 1) % 3));
      drop(4'h1, 2'h2);
      rd(16'h1c21, rv);
      chk(rv, {18'h0, rb, 2'((i + 1) % 3), 1'b1, codes[i], 2'(i % 3), 1'b1});
      tick();
      chk(drop_irq_o, 1'b0);
      rd(16'h1c21, rv); chk(rv, 32'h00000000);
    end
  endtask
  task automatic test_refused();
    for (int r = 7; r < 16; r++) begin
      if (r != 9) begin
        drop(4'(r), 2'h0);
      end
    end
    drop(4'h2, 2'h3);
    wr(16'h1c21, 32'h00003fff);
    chk(drop_irq_o, 1'b0);
    rd(16'h1c21, rv); chk(rv, 32'h00000000);
  endtask
  task automatic test_masked_capture();
    wr(16'h1c20, 32'h00000001);
    drop(4'h6, 2'h1);
    tick();
    chk(drop_irq_o, 1'b0);
    wr(16'h1c20, 32'h00000000);
    chk(drop_irq_o, 1'b1);
    rd(16'h1c21, rv); chk(rv, 32'h00000033);
    chk(drop_irq_o, 1'b0);
  endtask
  // A drop in the cycle of a clearing read survives the clear and shows in the next read.
  task automatic test_read_races();
    p2_rate_drop_i = 1'b1;
    repeat (2) tick();
    reg_addr_i = 16'h1c18;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    p2_rate_drop_i = 1'b0;
    chk(reg_rdata_o, 32'h00000002);
    tick();
    rd(16'h1c18, rv); chk(rv, 32'h00000001);
    drop(4'h5, 2'h2);
    drop_reason_i = 4'h3;
    drop_port_i = 2'h0;
    drop_event_i = 1'b1;
    reg_addr_i = 16'h1c21;
    reg_rd_i = 1'b1;
    tick();
    reg_rd_i = 1'b0;
    drop_event_i = 1'b0;
    chk(reg_rdata_o, 32'h0000002d);
    chk(drop_irq_o, 1'b1);
    tick();
    rd(16'h1c21, rv); chk(rv, 32'h00000019);
  endtask
  // Reset in mid-run with the counter, mask and pending record all away from their reset values.
  task automatic test_reset_again();
    drop(4'h2, 2'h1);
    p2_rate_drop_i = 1'b1;
    tick();
    p2_rate_drop_i = 1'b0;
    chk(drop_irq_o, 1'b1);
    resetn_i = 1'b0;
    repeat (2) tick();
    resetn_i = 1'b1;
    test_reset_values();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    test_reset_values();
    test_counter();
    test_mask_reg();
    test_pending_codes();
    test_refused();
    test_masked_capture();
    test_read_races();
    test_reset_again();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
